// File: rtl/delay_pulse_slaves.sv
// Purpose: slave channels 2 and 3 of a delay pulse output group
// Assumes: master channel events arrive as one-cycle pulses on pclk
// Notes:   prescaler outputs are enables from one free divider
//
// Overview of operation
// - slave 2 never drives a timer output
// - rewrite enable applies buffer only at trigger
// - rewrite control channel is the master or the own channel
// - master count start raises rewrite trigger
// - monitor bit 0 ignores channel interrupt
// - control select 0 monitors master always
// - clock select picks prescaler 0 to 3
// - count clock select 0 counts operation clock
// - master select 0 marks channel as slave
// - slave 3 starts on upper channel interrupt
// - mode 1010 is pulse one count
// - lowest mode bit: start interrupt, toggle, retrigger
// - output enable 1 blocks direct level
// - output mode 0 is independent output
// - polarity bit inverts timer output
// - dead time enable 0 inserts none
// - master zero reloads and starts slave 2
// - start bit self-clears after write
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module delay_pulse_slaves #(
    parameter int PRE_SHIFT = 2
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // master channel events
    input  wire logic        master_start,
    input  wire logic        master_zero,
    // channel events and pin
    output logic             channel_interrupt2,
    output logic             channel_interrupt3,
    output logic             timer_output
);
    logic [15:0] mode_ff [2];
    logic [15:0] nxt_mode [2];
    logic [15:0] buf_ff [2];
    logic [15:0] nxt_buf [2];
    logic [15:0] act_ff [2];
    logic [15:0] nxt_act [2];
    logic [15:0] cnt_ff [2];
    logic [15:0] nxt_cnt [2];
    dly_pkg::run_t run_ff [2];
    dly_pkg::run_t nxt_run [2];
    logic [1:0]  te_ff, nxt_te;
    logic [1:0]  irq_ff, nxt_irq;
    logic [1:0]  sub3_ff, nxt_sub3;
    logic [6:0]  oc_ff, nxt_oc;
    logic [7:0]  rw_ff, nxt_rw;
    logic [15:0] pre_ff, nxt_pre;
    logic        raw_ff, nxt_raw;
    logic        tout_ff, nxt_tout;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        rdy_ff, nxt_rdy;
    logic        err_ff, nxt_err;
    logic [1:0]  st, fin, tick, rwt;
    logic        wr;

    function automatic logic pre_tick(logic [15:0] c, logic [1:0] s);
        logic [15:0] m;
        m = (16'h0001 << (32'(s) * PRE_SHIFT)) - 16'h0001;
        return (c & m) == 16'h0000;
    endfunction

    function automatic logic [3:0] md_of(logic [15:0] r);
        return r[dly_pkg::MD_LSB +: 4];
    endfunction

    function automatic logic mapped(logic [7:0] a);
        return a <= dly_pkg::OFS_START && a[1:0] == 2'b00;
    endfunction

    assign wr = psel && penable && rdy_ff && pwrite;

    // channel counters, rewrite buffers and timer output
    always_comb begin
        logic       src, legal, md0;
        logic [3:0] bits;
        src   = 1'b0;
        legal = 1'b0;
        md0   = 1'b0;
        bits  = 4'h0;
        st    = 2'b00;
        fin   = 2'b00;
        tick  = 2'b00;
        rwt   = 2'b00;
        nxt_pre = pre_ff + 16'h0001;
        nxt_raw = raw_ff;
        for (int i = 0; i < 2; i++) begin
            md0 = mode_ff[i][dly_pkg::MD0_BIT];
            tick[i] = pre_tick(pre_ff,
                mode_ff[i][dly_pkg::CKS_LSB +: 2])
                && !mode_ff[i][dly_pkg::CCS_BIT];
            if (i == 0) begin
                src = mode_ff[0][dly_pkg::STS_LSB +: 3]
                    == dly_pkg::STS_MASTER
                    && (master_start || master_zero);
            end else begin
                src = mode_ff[1][dly_pkg::STS_LSB +: 3]
                    == dly_pkg::STS_UPPER && irq_ff[0];
            end
            legal = te_ff[i] && !mode_ff[i][dly_pkg::MAS_BIT]
                && md_of(mode_ff[i]) == ((i == 0) ?
                dly_pkg::MD_ONE : dly_pkg::MD_PULSE);
            st[i] = legal && src
                && (run_ff[i] == dly_pkg::ST_IDLE || md0);
            nxt_cnt[i] = cnt_ff[i];
            nxt_run[i] = run_ff[i];
            case (run_ff[i])
                dly_pkg::ST_IDLE: begin
                    if (st[i]) begin
                        nxt_cnt[i] = act_ff[i];
                        nxt_run[i] = dly_pkg::ST_COUNT;
                    end
                end
                dly_pkg::ST_COUNT: begin
                    if (!te_ff[i]) begin
                        nxt_run[i] = dly_pkg::ST_IDLE;
                    end else if (st[i]) begin
                        nxt_cnt[i] = act_ff[i];
                    end else if (tick[i]) begin
                        if (cnt_ff[i] == 16'h0000) begin
                            fin[i]     = 1'b1;
                            nxt_run[i] = dly_pkg::ST_IDLE;
                        end else begin
                            nxt_cnt[i] = cnt_ff[i] - 16'h0001;
                        end
                    end
                end
                default: nxt_run[i] = dly_pkg::ST_IDLE;
            endcase
            nxt_irq[i] = (st[i] && md0) || fin[i];
            // a monitored interrupt only counts when asked for
            bits = rw_ff[i*dly_pkg::RW_STRIDE +: 4];
            if (bits[dly_pkg::RW_SEL]) begin
                rwt[i] = bits[dly_pkg::RW_MON] && irq_ff[i];
            end else begin
                rwt[i] = bits[dly_pkg::RW_MOD] ? master_start
                    : master_zero;
            end
            nxt_act[i] = (!bits[dly_pkg::RW_RDE] || rwt[i]) ?
                buf_ff[i] : act_ff[i];
        end
        // only slave 3 owns a pin; slave 2 output stays free
        if (st[1] && mode_ff[1][dly_pkg::MD0_BIT]) begin
            nxt_raw = !nxt_raw;
        end
        if (fin[1]) begin
            nxt_raw = !nxt_raw;
        end
        // no partner channel here, so dead time never applies
        if (!oc_ff[dly_pkg::OC_OE]) begin
            nxt_tout = oc_ff[dly_pkg::OC_DIR];
        end else if (!oc_ff[dly_pkg::OC_MS]
                     && !oc_ff[dly_pkg::OC_CFG]) begin
            nxt_tout = raw_ff ^ oc_ff[dly_pkg::OC_POL];
        end else begin
            nxt_tout = tout_ff;
        end
    end

    // apb register file
    always_comb begin
        nxt_mode = mode_ff;
        nxt_buf  = buf_ff;
        nxt_sub3 = sub3_ff;
        nxt_oc   = oc_ff;
        nxt_rw   = rw_ff;
        nxt_te   = te_ff;
        if (wr) begin
            case (paddr)
                dly_pkg::OFS_MODE2: nxt_mode[0] = pwdata[15:0];
                dly_pkg::OFS_MODE3: nxt_mode[1] = pwdata[15:0];
                dly_pkg::OFS_SUB3:  nxt_sub3    = pwdata[1:0];
                dly_pkg::OFS_DATA2: nxt_buf[0]  = pwdata[15:0];
                dly_pkg::OFS_DATA3: nxt_buf[1]  = pwdata[15:0];
                dly_pkg::OFS_OUT:   nxt_oc = pwdata[dly_pkg::OC_W-1:0];
                dly_pkg::OFS_RW:    nxt_rw      = pwdata[7:0];
                dly_pkg::OFS_START: begin
                    // stop wins over start written in one word
                    nxt_te = (te_ff | pwdata[dly_pkg::ST_GO +: 2])
                        & ~pwdata[dly_pkg::ST_HLT +: 2];
                end
                default: nxt_te = te_ff;
            endcase
        end
        nxt_rdy   = psel && !penable;
        nxt_err   = psel && !penable && !mapped(paddr);
        nxt_rdata = 32'h0000_0000;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                dly_pkg::OFS_MODE2: nxt_rdata[15:0] = mode_ff[0];
                dly_pkg::OFS_MODE3: nxt_rdata[15:0] = mode_ff[1];
                dly_pkg::OFS_SUB3:  nxt_rdata[1:0]  = sub3_ff;
                dly_pkg::OFS_DATA2: nxt_rdata[15:0] = buf_ff[0];
                dly_pkg::OFS_DATA3: nxt_rdata[15:0] = buf_ff[1];
                dly_pkg::OFS_CNT2:  nxt_rdata[15:0] = cnt_ff[0];
                dly_pkg::OFS_CNT3:  nxt_rdata[15:0] = cnt_ff[1];
                dly_pkg::OFS_OUT:
                    nxt_rdata[dly_pkg::OC_W-1:0] = oc_ff;
                dly_pkg::OFS_RW:    nxt_rdata[7:0] = rw_ff;
                dly_pkg::OFS_START: begin
                    nxt_rdata[dly_pkg::ST_HLT +: 2] = te_ff;
                    nxt_rdata[dly_pkg::ST_RUN]   = run_ff[0];
                    nxt_rdata[dly_pkg::ST_RUN+1] = run_ff[1];
                end
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                mode_ff[i] <= dly_pkg::MODE_RST;
                buf_ff[i]  <= dly_pkg::DATA_RST;
                act_ff[i]  <= dly_pkg::DATA_RST;
                cnt_ff[i]  <= dly_pkg::DATA_RST;
                run_ff[i]  <= dly_pkg::ST_IDLE;
            end
            te_ff    <= 2'h0;
            irq_ff   <= 2'h0;
            sub3_ff  <= 2'h0;
            oc_ff    <= 7'h00;
            rw_ff    <= 8'h00;
            pre_ff   <= 16'h0000;
            raw_ff   <= 1'b0;
            tout_ff  <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rdy_ff   <= 1'b0;
            err_ff   <= 1'b0;
        end else begin
            mode_ff  <= nxt_mode;
            buf_ff   <= nxt_buf;
            act_ff   <= nxt_act;
            cnt_ff   <= nxt_cnt;
            run_ff   <= nxt_run;
            te_ff    <= nxt_te;
            irq_ff   <= nxt_irq;
            sub3_ff  <= nxt_sub3;
            oc_ff    <= nxt_oc;
            rw_ff    <= nxt_rw;
            pre_ff   <= nxt_pre;
            raw_ff   <= nxt_raw;
            tout_ff  <= nxt_tout;
            rdata_ff <= nxt_rdata;
            rdy_ff   <= nxt_rdy;
            err_ff   <= nxt_err;
        end
    end

    assign prdata             = rdata_ff;
    assign pready             = rdy_ff;
    assign pslverr            = err_ff;
    assign channel_interrupt2 = irq_ff[0];
    assign channel_interrupt3 = irq_ff[1];
    assign timer_output       = tout_ff;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s2_go;
        st[0] ##1 run_ff[0] == dly_pkg::ST_COUNT;
    endsequence

    start_bit_a: assert property (wr && paddr == dly_pkg::OFS_START
        && pwdata[0] && !pwdata[2] |=> te_ff[0] ##1 !rdata_ff[0])
        else $error("start bit did not arm or did not clear");
    s2_reload_a: assert property (st[0] |-> s2_go
        and (##1 cnt_ff[0] == $past(act_ff[0])))
        else $error("slave 2 did not reload on master event");
    s3_upper_a: assert property (st[1] |-> irq_ff[0]
        && mode_ff[1][10:8] == dly_pkg::STS_UPPER)
        else $error("slave 3 started without upper interrupt");
    rw_hold_a: assert property (rw_ff[dly_pkg::RW_RDE] && !rwt[0]
        |=> $stable(act_ff[0]))
        else $error("buffered data applied without trigger");
    rw_master_a: assert property (rw_ff[3:0] == 4'h5
        && master_start |=> act_ff[0] == $past(buf_ff[0]))
        else $error("master start did not rewrite data");
    rw_monitor_a: assert property (rw_ff[7:4] == 4'h3
        |=> $stable(act_ff[1]))
        else $error("unmonitored interrupt caused rewrite");
    hold_count_a: assert property (run_ff[0] == dly_pkg::ST_COUNT
        && !tick[0] && !st[0] && te_ff[0] |=> $stable(cnt_ff[0]))
        else $error("slave 2 counted without operation clock");
    s3_start_a: assert property (st[1] && mode_ff[1][0]
        |=> irq_ff[1] && raw_ff != $past(raw_ff))
        else $error("slave 3 start lacked interrupt or toggle");
    polarity_a: assert property (oc_ff[2:0] == 3'h1 ##1
        oc_ff[2:0] == 3'h1 |-> tout_ff == $past(raw_ff ^ oc_ff[3]))
        else $error("timer output polarity wrong");
    direct_a: assert property (!oc_ff[dly_pkg::OC_OE]
        |=> tout_ff == $past(oc_ff[dly_pkg::OC_DIR]))
        else $error("direct level not driven when allowed");
endmodule // delay_pulse_slaves

// File: common/dly_pkg.sv
// Purpose: shared constants for the delay pulse slave channel pair
// Assumes: apb byte addresses, one 32-bit word per register
// Notes:   index 0 is slave channel 2, index 1 is slave channel 3
package dly_pkg;
    localparam int AW = 8;
    localparam logic [7:0] OFS_MODE2 = 8'h00;
    localparam logic [7:0] OFS_MODE3 = 8'h04;
    localparam logic [7:0] OFS_SUB3  = 8'h08;
    localparam logic [7:0] OFS_DATA2 = 8'h0C;
    localparam logic [7:0] OFS_DATA3 = 8'h10;
    localparam logic [7:0] OFS_CNT2  = 8'h14;
    localparam logic [7:0] OFS_CNT3  = 8'h18;
    localparam logic [7:0] OFS_OUT   = 8'h1C;
    localparam logic [7:0] OFS_RW    = 8'h20;
    localparam logic [7:0] OFS_START = 8'h24;
    // channel_mode_reg fields
    localparam int CKS_LSB = 14;
    localparam int CCS_BIT = 12;
    localparam int MAS_BIT = 11;
    localparam int STS_LSB = 8;
    localparam int MD_LSB  = 1;
    localparam int MD0_BIT = 0;
    localparam logic [2:0] STS_MASTER = 3'h4;
    localparam logic [2:0] STS_UPPER  = 3'h5;
    localparam logic [3:0] MD_ONE     = 4'h4;
    localparam logic [3:0] MD_PULSE   = 4'hA;
    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [15:0] DATA_RST  = 16'h0000;
    // output control register bits
    localparam int OC_OE  = 0;
    localparam int OC_MS  = 1;
    localparam int OC_CFG = 2;
    localparam int OC_POL = 3;
    localparam int OC_DTE = 4;
    localparam int OC_DTL = 5;
    localparam int OC_DIR = 6;
    localparam int OC_W   = 7;
    // rewrite register: four bits per channel
    localparam int RW_RDE = 0;
    localparam int RW_SEL = 1;
    localparam int RW_MOD = 2;
    localparam int RW_MON = 3;
    localparam int RW_STRIDE = 4;
    // start register: start bits 1:0, stop bits 3:2, run status 5:4
    localparam int ST_GO  = 0;
    localparam int ST_HLT = 2;
    localparam int ST_RUN = 4;
    typedef enum logic {ST_IDLE = 1'b0, ST_COUNT = 1'b1} run_t;
endpackage

// File: sim/delay_pulse_slaves_tb_top.sv
// Purpose: self-checking bench for the delay pulse slave channel pair
// Assumes: one-cycle apb access, master events as one-cycle pulses
// Notes:   prescaler k ticks every 4**k pclk with PRE_SHIFT 2
`timescale 1ns/100ps
module delay_pulse_slaves_tb_top;
    logic        pclk         = 1'b0;
    logic        presetn      = 1'b0;
    logic        psel         = 1'b0;
    logic        penable      = 1'b0;
    logic        pwrite       = 1'b0;
    logic [7:0]  paddr        = 8'h00;
    logic [31:0] pwdata       = 32'h0000_0000;
    logic        master_start = 1'b0;
    logic        master_zero  = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq2;
    logic        irq3;
    logic        tout;
    logic [31:0] rd;
    logic        er;
    int          errors       = 0;
    int          checks_done  = 0;
    int          n2, n3, nt, t1, t2, per;
    logic [31:0] oc_v [4] = '{32'h0000_0009, 32'h0000_0041,
                              32'h0000_0040, 32'h0000_0000};
    logic        pin_v [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    always #20 pclk = ~pclk;

    delay_pulse_slaves #(.PRE_SHIFT(2)) dut (
        .pclk               (pclk),
        .presetn            (presetn),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .master_start       (master_start),
        .master_zero        (master_zero),
        .channel_interrupt2 (irq2),
        .channel_interrupt3 (irq3),
        .timer_output       (tout)
    );

    task automatic print_verdict();
        if (errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_range(input string what, input int lo,
                               input int hi, input int got);
        checks_done++;
        if (got < lo || got > hi) begin
            errors++;
            $display("unexpected %s: expected %0d..%0d seen %0d",
                     what, lo, hi, got);
        end
    endtask

    // requests stay put until pready is seen high, then release
    // only the watchdog limits the wait, so a dead slave still ends the run
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        check("pready latency", 32'd1, 32'(k));
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(what, exp, rd);
    endtask

    // one master zero pulse, then tally events over span cycles
    task automatic fire(input int span);
        logic last;
        master_zero <= 1'b1;
        @(posedge pclk);
        master_zero <= 1'b0;
        n2 = 0;
        n3 = 0;
        nt = 0;
        t1 = 0;
        t2 = 0;
        last = tout;
        for (int i = 0; i < span; i++) begin
            @(negedge pclk);
            if (irq2 === 1'b1) begin
                n2++;
                if (n2 == 1) t1 = i; else t2 = i;
            end
            if (irq3 === 1'b1) n3++;
            if (tout !== last) nt++;
            last = tout;
        end
        @(posedge pclk);
    endtask

    task automatic counts(input int e2, input int e3, input int et);
        check("irq2 count", 32'(e2), 32'(n2));
        check("irq3 count", 32'(e3), 32'(n3));
        check("toggle count", 32'(et), 32'(nt));
    endtask

    initial begin
        #(40 * 30000);
        errors++;
        print_verdict();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("mode2 reset", dly_pkg::OFS_MODE2, {16'h0, dly_pkg::MODE_RST});
        rdc("data2 reset", dly_pkg::OFS_DATA2, {16'h0, dly_pkg::DATA_RST});
        apb(1'b0, 8'h28, 32'h0000_0000);
        check("unmapped data", 32'h0000_0000, rd);
        check("unmapped err", 32'd1, {31'd0, er});
        wr(dly_pkg::OFS_SUB3, 32'h0000_0000);
        wr(dly_pkg::OFS_OUT, 32'h0000_0001);
        wr(dly_pkg::OFS_RW, 32'h0000_0000);
        wr(dly_pkg::OFS_DATA3, 32'h0000_0000);
        wr(dly_pkg::OFS_DATA2, 32'h0000_0003);
        // every clock select code; gap between irq2 pulses scales
        for (int k = 0; k < 4; k++) begin
            per = 1 << (2 * k);
            wr(dly_pkg::OFS_MODE2, {16'h0, 2'(k), 14'h0409});
            wr(dly_pkg::OFS_MODE3, {16'h0, 2'(k), 14'h0515});
            rdc("mode3 readback", dly_pkg::OFS_MODE3,
                {16'h0, 2'(k), 14'h0515});
            wr(dly_pkg::OFS_START, 32'h0000_0003);
            rdc("start bits", dly_pkg::OFS_START, 32'h0000_000C);
            fire(400);
            check_range("gap2", 3 * per + 1, 4 * per, t2 - t1);
            counts(2, 4, 4);
        end
        // external count clock: no input, counter holds its load
        wr(dly_pkg::OFS_MODE2, 32'h0000_1409);
        wr(dly_pkg::OFS_START, 32'h0000_0001);
        fire(100);
        check("irq2 stalled", 32'd1, 32'(n2));
        rdc("cnt2 stalled", dly_pkg::OFS_CNT2, 32'h0000_0003);
        wr(dly_pkg::OFS_MODE2, 32'h0000_0409);
        wr(dly_pkg::OFS_MODE3, 32'h0000_0514);
        fire(50);
        counts(2, 2, 2);
        // buffered data only moves at a master start
        wr(dly_pkg::OFS_MODE3, 32'h0000_0515);
        wr(dly_pkg::OFS_RW, 32'h0000_0055);
        wr(dly_pkg::OFS_DATA2, 32'h0000_0007);
        fire(50);
        check("gap old data", 32'd4, 32'(t2 - t1));
        master_start <= 1'b1;
        @(posedge pclk);
        master_start <= 1'b0;
        @(posedge pclk);
        fire(50);
        check("gap new data", 32'd8, 32'(t2 - t1));
        wr(dly_pkg::OFS_START, 32'h0000_0008);
        fire(50);
        counts(2, 0, 0);
        wr(dly_pkg::OFS_START, 32'h0000_0004);
        wr(dly_pkg::OFS_START, 32'h0000_0002);
        fire(50);
        counts(0, 0, 0);
        // raw level is low here after an even number of toggles
        for (int j = 0; j < 4; j++) begin
            wr(dly_pkg::OFS_OUT, oc_v[j]);
            repeat (3) @(negedge pclk);
            check("timer output", {31'd0, pin_v[j]},
                  {31'd0, tout});
            @(posedge pclk);
        end
        wr(dly_pkg::OFS_START, 32'h0000_0001);
        wr(dly_pkg::OFS_OUT, 32'h0000_0003);
        fire(50);
        counts(2, 4, 0);
        wr(dly_pkg::OFS_OUT, 32'h0000_0015);
        fire(50);
        counts(2, 4, 0);
        // own interrupt selected but not monitored: slave 3 data frozen
        wr(dly_pkg::OFS_OUT, 32'h0000_0001);
        wr(dly_pkg::OFS_RW, 32'h0000_0035);
        wr(dly_pkg::OFS_DATA3, 32'h0000_0005);
        fire(50);
        counts(2, 4, 4);
        print_verdict();
    end
endmodule // delay_pulse_slaves_tb_top
